// file: hw/dmx_pkg.sv
package dmx_pkg;

    // ****************************************************************
    // Widths
    // ****************************************************************
    localparam int DMX_WORD_W = 16;
    localparam int DMX_ADDR_W = 12;
    localparam int DMX_DATA_W = 8;

    // ****************************************************************
    // Opcode patterns
    // ****************************************************************
    localparam logic [3:0] DMX_OPC_MOVE_FIRST = 4'hc;  // First word of file-to-file move
    localparam logic [3:0] DMX_OPC_MOVE_SECOND = 4'hf; // Second word of file-to-file move
    localparam logic [7:0] DMX_OPC_BANK_LIT = 8'h01;   // Load bank literal
    localparam logic [7:0] DMX_OPC_ACC_LIT = 8'h0e;    // Load accumulator literal
    localparam logic [6:0] DMX_OPC_STORE = 7'h37;      // Store accumulator, bit 8 is access select

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int DMX_ACCESS_BIT = 8;

    // ****************************************************************
    // Data space layout
    // ****************************************************************
    localparam logic [11:0] DMX_ACC_ADDR = 12'hfe8;    // Accumulator location in data space
    localparam logic [7:0] DMX_ACCESS_SPLIT = 8'h80;   // Access bank low/high split
    localparam logic [3:0] DMX_ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] DMX_ACCESS_HI_BANK = 4'hf;

    // ****************************************************************
    // Reset values
    // ****************************************************************
    localparam logic [7:0] DMX_ACC_RESET = 8'h00;
    localparam logic [7:0] DMX_BANK_RESET = 8'h00;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [1:0] {
        DMX_PH_Q1 = 2'b00,
        DMX_PH_Q2 = 2'b01,
        DMX_PH_Q3 = 2'b10,
        DMX_PH_Q4 = 2'b11
    } dmx_phase_e;

    typedef enum logic [0:0] {
        DMX_ST_DECODE = 1'b0,
        DMX_ST_SECOND = 1'b1
    } dmx_state_e;

    typedef enum logic [2:0] {
        DMX_OP_NONE = 3'b000,
        DMX_OP_MOVE_RD = 3'b001,
        DMX_OP_MOVE_WAIT = 3'b010,
        DMX_OP_MOVE_WR = 3'b011,
        DMX_OP_BANK = 3'b100,
        DMX_OP_ACC = 3'b101,
        DMX_OP_STORE = 3'b110
    } dmx_op_e;

endpackage

// file: hw/dmx_qphase.sv
module dmx_qphase
    import dmx_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    output dmx_phase_e phase_q
);

    typedef struct packed {
        dmx_phase_e phase;
    } dmx_qphase_s;

    dmx_qphase_s s_q;
    dmx_qphase_s s_d;

    // Quarter phases advance Q1 to Q4 and wrap
    always_comb begin
        s_d = s_q;
        unique case (s_q.phase)
            DMX_PH_Q1: s_d.phase = DMX_PH_Q2;
            DMX_PH_Q2: s_d.phase = DMX_PH_Q3;
            DMX_PH_Q3: s_d.phase = DMX_PH_Q4;
            DMX_PH_Q4: s_d.phase = DMX_PH_Q1;
        endcase
    end

    // Phase register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{phase: DMX_PH_Q1};
        end else begin
            s_q <= s_d;
        end
    end

    assign phase_q = s_q.phase;

endmodule // dmx_qphase

// file: hw/dmx_exec.sv
// Operation
// (RULE_01) Move takes full 12-bit source and destination
// (RULE_02) Accumulator may be move source or destination
// (RULE_03) Software never targets program counter or stack
// (RULE_04) Software avoids moving interrupt settings while enabled
// (RULE_05) Move is two words, two or three cycles
// (RULE_06) Source read Q2 first, write Q4 second
// (RULE_07) Bank literal opcode loads bank select register
// (RULE_08) Accumulator literal loads accumulator, one cycle
// (RULE_09) Store copies accumulator to file, one cycle
// (RULE_10) Store address selects any byte in bank
// (RULE_11) Access select zero targets the access bank
// (RULE_12) Access select one uses bank select register
module dmx_exec
    import dmx_pkg::*;
#(
    parameter logic [11:0] ACC_ADDR = DMX_ACC_ADDR
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input wire logic [DMX_WORD_W-1:0] instr_word,
    input wire logic [DMX_DATA_W-1:0] mem_rdata,
    output logic instr_fetch,
    output logic busy,
    output logic mem_rd,
    output logic mem_wr,
    output logic [DMX_ADDR_W-1:0] mem_addr,
    output logic [DMX_DATA_W-1:0] mem_wdata,
    output logic [DMX_DATA_W-1:0] acc_q,
    output logic [DMX_DATA_W-1:0] bank_sel_q
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        dmx_state_e st;
        dmx_op_e op;
        logic [DMX_ADDR_W-1:0] addr;
        logic [DMX_DATA_W-1:0] lit;
        logic [DMX_DATA_W-1:0] dat;
        logic [DMX_DATA_W-1:0] acc;
        logic [DMX_DATA_W-1:0] bank;
        logic fetch;
        logic busy;
        logic rd;
        logic wr;
        logic [DMX_ADDR_W-1:0] maddr;
        logic [DMX_DATA_W-1:0] wdata;
    } dmx_exec_s;

    dmx_exec_s s_q;
    dmx_exec_s s_d;
    dmx_phase_e phase;
    logic taken;
    logic [DMX_ADDR_W-1:0] store_addr;

    // ****************************************************************
    // Quarter phase sequencer
    // ****************************************************************
    dmx_qphase u_qphase (
        .clk(clk),
        .rst_b(rst_b),
        .phase_q(phase)
    );

    assign taken = (phase == DMX_PH_Q1) && instr_valid;

    // Banked store address: access bank or bank select register
    always_comb begin
        store_addr = {s_q.bank[3:0], instr_word[7:0]}; // RULE_12
        if (!instr_word[DMX_ACCESS_BIT]) begin
            if (instr_word[7:0] < DMX_ACCESS_SPLIT) begin
                store_addr = {DMX_ACCESS_LO_BANK, instr_word[7:0]}; // RULE_11
            end else begin
                store_addr = {DMX_ACCESS_HI_BANK, instr_word[7:0]}; // RULE_11
            end
        end
    end

    // ****************************************************************
    // Decode and execute
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        s_d.rd = 1'b0;
        s_d.wr = 1'b0;
        s_d.fetch = (phase == DMX_PH_Q4);
        unique case (phase)
            DMX_PH_Q1: begin
                if (s_q.st == DMX_ST_SECOND) begin
                    if (!instr_valid) begin
                        s_d.op = DMX_OP_MOVE_WAIT; // RULE_05
                    end else if (instr_word[15:12] == DMX_OPC_MOVE_SECOND) begin
                        s_d.op = DMX_OP_MOVE_WR;
                        s_d.addr = instr_word[11:0]; // RULE_01
                        s_d.st = DMX_ST_DECODE;
                    end else begin
                        s_d.op = DMX_OP_NONE; // Broken pair is dropped
                        s_d.st = DMX_ST_DECODE;
                    end
                end else if (!instr_valid) begin
                    s_d.op = DMX_OP_NONE;
                end else if (instr_word[15:12] == DMX_OPC_MOVE_FIRST) begin
                    s_d.op = DMX_OP_MOVE_RD;
                    s_d.st = DMX_ST_SECOND;
                    s_d.addr = instr_word[11:0]; // RULE_01
                    s_d.maddr = instr_word[11:0];
                    s_d.rd = (instr_word[11:0] != ACC_ADDR); // RULE_06
                end else if (instr_word[15:8] == DMX_OPC_BANK_LIT) begin
                    s_d.op = DMX_OP_BANK;
                    s_d.lit = instr_word[7:0];
                end else if (instr_word[15:8] == DMX_OPC_ACC_LIT) begin
                    s_d.op = DMX_OP_ACC;
                    s_d.lit = instr_word[7:0];
                end else if (instr_word[15:9] == DMX_OPC_STORE) begin
                    s_d.op = DMX_OP_STORE;
                    s_d.maddr = store_addr; // RULE_10
                end else begin
                    s_d.op = DMX_OP_NONE;
                end
            end
            DMX_PH_Q2: begin
                // Source byte, accumulator served internally
                if (s_q.op == DMX_OP_MOVE_RD) begin
                    s_d.dat = (s_q.addr == ACC_ADDR) ? s_q.acc : mem_rdata; // RULE_02
                end
            end
            DMX_PH_Q3: begin
                unique case (s_q.op)
                    DMX_OP_BANK: s_d.bank = s_q.lit; // RULE_07
                    DMX_OP_ACC: s_d.acc = s_q.lit; // RULE_08
                    DMX_OP_STORE: begin
                        s_d.wr = 1'b1; // RULE_09
                        s_d.wdata = s_q.acc;
                    end
                    DMX_OP_MOVE_WR: begin
                        if (s_q.addr == ACC_ADDR) begin
                            s_d.acc = s_q.dat; // RULE_02
                        end else begin
                            s_d.wr = 1'b1; // RULE_06
                            s_d.maddr = s_q.addr;
                            s_d.wdata = s_q.dat;
                        end
                    end
                    default: s_d.wr = 1'b0;
                endcase
            end
            DMX_PH_Q4: begin
                s_d.busy = (s_q.st == DMX_ST_SECOND); // RULE_05
            end
        endcase
        if (taken && s_q.st == DMX_ST_DECODE && instr_word[15:12] == DMX_OPC_MOVE_FIRST) begin
            s_d.busy = 1'b1;
        end
    end

    // State register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s_q <= '{st: DMX_ST_DECODE, op: DMX_OP_NONE, addr: '0, lit: '0, dat: '0,
                     acc: DMX_ACC_RESET, bank: DMX_BANK_RESET, fetch: 1'b1, busy: 1'b0,
                     rd: 1'b0, wr: 1'b0, maddr: '0, wdata: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs straight from the state register
    assign instr_fetch = s_q.fetch;
    assign busy = s_q.busy;
    assign mem_rd = s_q.rd;
    assign mem_wr = s_q.wr;
    assign mem_addr = s_q.maddr;
    assign mem_wdata = s_q.wdata;
    assign acc_q = s_q.acc;
    assign bank_sel_q = s_q.bank;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence seq_first_mem;
        taken && s_q.st == DMX_ST_DECODE && instr_word[15:12] == DMX_OPC_MOVE_FIRST
            && instr_word[11:0] != ACC_ADDR;
    endsequence

    sequence seq_second_taken;
        taken && s_q.st == DMX_ST_SECOND && instr_word[15:12] == DMX_OPC_MOVE_SECOND;
    endsequence

    sequence seq_store;
        taken && s_q.st == DMX_ST_DECODE && instr_word[15:9] == DMX_OPC_STORE;
    endsequence

    chk_move_src_read: assert property ( // RULE_06
        seq_first_mem |=> mem_rd && mem_addr == $past(instr_word[11:0]))
        else $error("move source read missing in Q2");
    chk_move_acc_src: assert property ( // RULE_02
        taken && s_q.st == DMX_ST_DECODE && instr_word[15:12] == DMX_OPC_MOVE_FIRST
            && instr_word[11:0] == ACC_ADDR |=> !mem_rd)
        else $error("accumulator source went to memory");
    chk_move_dst_write: assert property ( // RULE_01
        seq_second_taken and (instr_word[11:0] != ACC_ADDR)
            |-> ##3 mem_wr && mem_addr == $past(instr_word[11:0], 3))
        else $error("move destination write wrong");
    chk_move_no_dummy: assert property ( // RULE_06
        seq_second_taken |=> (!mem_rd && !mem_wr) [*2])
        else $error("dummy access during move second cycle");
    chk_move_acc_dst: assert property ( // RULE_02
        seq_second_taken and (instr_word[11:0] == ACC_ADDR)
            |-> ##3 !mem_wr && acc_q == s_q.dat)
        else $error("accumulator destination not written");
    chk_move_stall: assert property ( // RULE_05
        phase == DMX_PH_Q1 && s_q.st == DMX_ST_SECOND && !instr_valid |=> busy [*4])
        else $error("move stall dropped busy");
    chk_bank_literal: assert property ( // RULE_07
        taken && s_q.st == DMX_ST_DECODE && instr_word[15:8] == DMX_OPC_BANK_LIT
            |-> ##3 bank_sel_q == $past(instr_word[7:0], 3))
        else $error("bank literal not loaded");
    chk_acc_literal: assert property ( // RULE_08
        taken && s_q.st == DMX_ST_DECODE && instr_word[15:8] == DMX_OPC_ACC_LIT
            |-> ##3 acc_q == $past(instr_word[7:0], 3))
        else $error("accumulator literal not loaded");
    chk_store_data: assert property ( // RULE_09
        seq_store |-> ##3 mem_wr && mem_wdata == acc_q)
        else $error("store did not write accumulator");
    chk_store_access: assert property ( // RULE_11
        seq_store and (!instr_word[DMX_ACCESS_BIT])
            |-> ##3 mem_addr[7:0] == $past(instr_word[7:0], 3)
                && (mem_addr[11:8] == DMX_ACCESS_LO_BANK || mem_addr[11:8] == DMX_ACCESS_HI_BANK))
        else $error("access bank store address wrong");
    chk_store_banked: assert property ( // RULE_12
        seq_store and instr_word[DMX_ACCESS_BIT]
            |-> ##3 mem_addr == {bank_sel_q[3:0], $past(instr_word[7:0], 3)})
        else $error("banked store address wrong");

endmodule // dmx_exec

// file: verif/test_dmx_exec.sv
module test_dmx_exec
    import dmx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************************************
    // Signals and bench state
    // ****************************************************************
    logic clk, rst_b, instr_valid, instr_fetch, busy, mem_rd, mem_wr;
    logic [DMX_WORD_W-1:0] instr_word;
    logic [DMX_DATA_W-1:0] mem_rdata, mem_wdata, acc_q, bank_sel_q;
    logic [DMX_ADDR_W-1:0] mem_addr, a1, a3;
    logic rd1, wr3, bz1;
    logic [7:0] d3, k, f, bank_select_register, acc, byte_v;
    logic [11:0] src, dst;
    logic [31:0] seed;
    int miscompares, cmp_count;
    // Program counter low byte and return stack top bytes; span placed by the bench
    localparam logic [11:0] PROT_DST_FIRST = 12'hff0;
    localparam logic [11:0] PROT_DST_LAST = 12'hff3;

    dmx_exec #(.ACC_ADDR(DMX_ACC_ADDR)) dmx_exec_i (.clk(clk), .rst_b(rst_b),
        .instr_valid(instr_valid), .instr_word(instr_word), .mem_rdata(mem_rdata),
        .instr_fetch(instr_fetch), .busy(busy), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .acc_q(acc_q), .bank_sel_q(bank_sel_q));

    // Clock at 100 MHz
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Galois shift register, fixed seed keeps runs repeatable
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
    endfunction

    // Expected target of a store from access bit, file byte and bank
    function automatic logic [11:0] store_addr(input logic a, input logic [7:0] fb,
                                                input logic [7:0] b);
        if (a) return {b[3:0], fb};
        if (fb < DMX_ACCESS_SPLIT) return {DMX_ACCESS_LO_BANK, fb};
        return {DMX_ACCESS_HI_BANK, fb};
    endfunction

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        cmp_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", nm, e, g);
            miscompares++;
        end
    endtask

    // Offers one word in Q1 and samples the memory port in the following clocks
    task automatic issue(input logic [15:0] w);
        int n;
        n = 0;
        while (instr_fetch !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        chk("instr_fetch in Q1", 12'h001, {11'h0, instr_fetch});
        instr_valid = 1'b1;
        instr_word = w;
        @(negedge clk);
        chk("instr_fetch in Q2", 12'h000, {11'h0, instr_fetch});
        instr_valid = 1'b0;
        seed = lfsr_next(seed);
        instr_word = seed[15:0];
        rd1 = mem_rd;
        a1 = mem_addr;
        bz1 = busy;
        @(negedge clk);
        @(negedge clk);
        wr3 = mem_wr;
        a3 = mem_addr;
        d3 = mem_wdata;
        @(negedge clk);
    endtask

    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Watchdog sized well above the expected run length
    initial begin
        #400000;
        miscompares++;
        tally_and_finish;
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        miscompares = 0;
        cmp_count = 0;
        seed = 32'hf1c570d2;
        rst_b = 1'b0;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        mem_rdata = 8'h00;
        repeat (10) @(negedge clk);
        rst_b = 1'b1;
        // Literal loads into bank select and accumulator
        for (int i = 0; i < 8; i++) begin
            seed = lfsr_next(seed);
            k = (i == 0) ? 8'hff : seed[7:0];
            issue({DMX_OPC_BANK_LIT, k});
            chk("bank_sel_q", {4'h0, k}, {4'h0, bank_sel_q});
            issue({DMX_OPC_ACC_LIT, ~k});
            chk("acc_q", {4'h0, ~k}, {4'h0, acc_q});
            chk("bank kept", {4'h0, k}, {4'h0, bank_sel_q});
        end
        $display("test literal loads done");
        // Stores with both access settings and boundary file bytes
        for (int i = 0; i < 16; i++) begin
            seed = lfsr_next(seed);
            f = (i < 4) ? (8'h7f + 8'(i % 2)) : seed[7:0];
            if (i == 2) f = 8'h00;
            if (i == 3) f = 8'hff;
            bank_select_register = seed[15:8];
            acc = seed[23:16];
            issue({DMX_OPC_BANK_LIT, bank_select_register});
            issue({DMX_OPC_ACC_LIT, acc});
            issue({DMX_OPC_STORE, i[0], f});
            chk("store mem_wr", 12'h001, {11'h0, wr3});
            chk("store mem_addr", store_addr(i[0], f, bank_select_register), a3);
            chk("store mem_wdata", {4'h0, acc}, {4'h0, d3});
            chk("store no read", 12'h000, {11'h0, rd1});
        end
        $display("test store done");
        // File-to-file moves, some stalled for a third cycle
        for (int i = 0; i < 12; i++) begin
            seed = lfsr_next(seed);
            src = (i == 0) ? 12'h000 : (i == 1) ? 12'hfff : seed[11:0];
            dst = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : seed[27:16];
            if (i == 4) src = DMX_ACC_ADDR;
            if (i == 5) dst = DMX_ACC_ADDR;
            if (i != 4 && src == DMX_ACC_ADDR) src = ~src;
            if (i != 5 && dst == DMX_ACC_ADDR) dst = ~dst;
            if (dst >= PROT_DST_FIRST && dst <= PROT_DST_LAST) dst = dst ^ 12'h100;
            byte_v = seed[7:0] ^ seed[31:24];
            mem_rdata = byte_v;
            acc = acc_q;
            issue({DMX_OPC_MOVE_FIRST, src});
            mem_rdata = ~byte_v;
            if (src == DMX_ACC_ADDR) byte_v = acc;
            chk("move busy", 12'h001, {11'h0, bz1});
            chk("move mem_rd", {11'h0, src != DMX_ACC_ADDR}, {11'h0, rd1});
            if (src != DMX_ACC_ADDR) chk("move src", src, a1);
            if (i[0]) begin
                repeat (4) @(negedge clk);
                chk("stall busy", 12'h001, {11'h0, busy});
                chk("stall no write", 12'h000, {11'h0, mem_wr});
            end
            // No interrupt source exists here, so no move runs with one enabled
            issue({DMX_OPC_MOVE_SECOND, dst});
            chk("move mem_wr", {11'h0, dst != DMX_ACC_ADDR}, {11'h0, wr3});
            if (dst == DMX_ACC_ADDR) begin
                chk("move acc_q", {4'h0, byte_v}, {4'h0, acc_q});
            end else begin
                chk("move dst", dst, a3);
                chk("move data", {4'h0, byte_v}, {4'h0, d3});
            end
            chk("move done", 12'h000, {11'h0, busy});
        end
        $display("test move done");
        // Broken move pair: the following word is dropped and nothing is written
        k = bank_sel_q;
        issue({DMX_OPC_MOVE_FIRST, 12'h123});
        issue({DMX_OPC_BANK_LIT, ~k});
        chk("abort no write", 12'h000, {11'h0, wr3});
        chk("abort bank kept", {4'h0, k}, {4'h0, bank_sel_q});
        chk("abort done", 12'h000, {11'h0, busy});
        $display("test broken move done");
        tally_and_finish;
    end
endmodule // test_dmx_exec
